// *** hdl/edge_timing_pkg.sv ***
// constants, register map and carriers of the edge timing control block
// ************************************************************
// Behaviour
// - polarity bit 0 makes a falling edge on the second source count
// - polarity bit 1 makes a rising edge on the second source count
// - four bit second source select field sits in control bits 21 to 18
// - codes f, e, d, c pick capture four, comparator b, comparator a, bus clock
// - codes b, a, 9 pick capture three, two and one
// - codes 8 down to 2 pick edge pins 13, 12, 11, 10, 9, 1, 2
// - code 1 picks compare one, code 0 picks the first timer
// - control bits 17, 16 and 14 always read zero
// - control bit 15 turns edge counting and delay generation on or off, the discharge sink does not depend on it
// - control bit 13 stops the unit while the chip idles
// - control bit 12 turns edge delay generation on or off
// - control bit 11 passes edges when set, blocks them when clear
// - capacitor sink connects only while the discharge bit is set
// - seen flag goes to 1 on a counted second edge, software may write it
// ************************************************************
package edge_timing_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] MEASURE_UNIT_CONTROL_OFS = 8'h00;
  localparam logic [7:0] IRQ_STATUS_OFS           = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS             = 8'h08;
  localparam logic [7:0] UNIT_STATE_OFS           = 8'h0c;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'hfffc_bfff;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int unsigned SEEN_BIT     = 25;
  localparam int unsigned POL_BIT      = 22;
  localparam int unsigned SEL_HI       = 21;
  localparam int unsigned SEL_LO       = 18;
  localparam int unsigned ON_BIT       = 15;
  localparam int unsigned SIDL_BIT     = 13;
  localparam int unsigned DELAY_GEN_ENABLE_BIT     = 12;
  localparam int unsigned GATE_BIT     = 11;
  localparam int unsigned DISCH_BIT    = 9;

  // interrupt status: counted edge, edge dropped while blocked
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_EDGE     = 0;
  localparam int unsigned IRQ_DROP     = 1;
  localparam logic [1:0]  IRQ_RESET    = 2'h0;

  typedef struct packed {
    logic input_capture_four;
    logic comparator_b_output;
    logic comparator_a_output;
    logic peripheral_bus_clock;
    logic input_capture_three;
    logic input_capture_two;
    logic input_capture_one;
    logic edge_pin_thirteen;
    logic edge_pin_twelve;
    logic edge_pin_eleven;
    logic edge_pin_ten;
    logic edge_pin_nine;
    logic edge_pin_one;
    logic edge_pin_two;
    logic output_compare_one;
    logic first_timer;
  } edge_src_s;

  typedef struct packed {
    logic [31:0]      ctrl;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic             prev;
    logic             evt;
    logic [31:0]      rdata;
  } unit_state_s;

endpackage : edge_timing_pkg

// *** hdl/edge_timing_unit_control.sv ***
// control register, second edge detection and interrupt of the timing unit
`timescale 1ns/1ps
module edge_timing_unit_control (
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic [7:0]                addr_i,
  input  wire logic [31:0]               wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [31:0]               rdata_o,
  input  wire edge_timing_pkg::edge_src_s edge_src_i,
  input  wire logic                      idle_i,
  output logic                           module_running_o,
  output logic                           delay_gen_o,
  output logic                           edge_b_event_o,
  output logic                           sample_cap_discharge_o,
  output logic                           irq_o
);

  // ************************************************************
  // source selection
  // ************************************************************
  function automatic logic pick_src(input logic [3:0] sel,
                                    input edge_timing_pkg::edge_src_s s);
    case (sel)
      4'hf:    pick_src = s.input_capture_four;
      4'he:    pick_src = s.comparator_b_output;
      4'hd:    pick_src = s.comparator_a_output;
      4'hc:    pick_src = s.peripheral_bus_clock;
      4'hb:    pick_src = s.input_capture_three;
      4'ha:    pick_src = s.input_capture_two;
      4'h9:    pick_src = s.input_capture_one;
      4'h8:    pick_src = s.edge_pin_thirteen;
      4'h7:    pick_src = s.edge_pin_twelve;
      4'h6:    pick_src = s.edge_pin_eleven;
      4'h5:    pick_src = s.edge_pin_ten;
      4'h4:    pick_src = s.edge_pin_nine;
      4'h3:    pick_src = s.edge_pin_one;
      4'h2:    pick_src = s.edge_pin_two;
      4'h1:    pick_src = s.output_compare_one;
      default: pick_src = s.first_timer;
    endcase
  endfunction : pick_src

  edge_timing_pkg::unit_state_s st_r;
  edge_timing_pkg::unit_state_s st_nxt;

  logic       cur;
  logic       pol;
  logic       running;
  logic       pass;
  logic       pol_edge;
  logic       qual;
  logic       wr_ctrl;
  logic       rd_ist;
  logic [3:0] sel;

  // ************************************************************
  // edge qualification
  // ************************************************************
  assign sel      = st_r.ctrl[edge_timing_pkg::SEL_HI:edge_timing_pkg::SEL_LO];
  assign pol      = st_r.ctrl[edge_timing_pkg::POL_BIT];
  assign cur      = pick_src(sel, edge_src_i);
  // idle only stops the unit when software asked for it
  assign running  = st_r.ctrl[edge_timing_pkg::ON_BIT] &
                    ~(st_r.ctrl[edge_timing_pkg::SIDL_BIT] & idle_i);
  assign pass     = running & st_r.ctrl[edge_timing_pkg::GATE_BIT];
  assign pol_edge = pol ? (cur & ~st_r.prev)
                        : (~cur & st_r.prev);
  // the sampler keeps running while blocked so no stale edge fires on release
  assign qual     = pass & pol_edge;
  assign wr_ctrl  = wr_i && (addr_i == edge_timing_pkg::MEASURE_UNIT_CONTROL_OFS);
  assign rd_ist   = rd_i && (addr_i == edge_timing_pkg::IRQ_STATUS_OFS);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = cur;
    st_nxt.evt  = qual;
    if (wr_ctrl) begin
      st_nxt.ctrl = wdata_i & edge_timing_pkg::CTRL_WMASK;
    end
    if (qual) begin
      st_nxt.ctrl[edge_timing_pkg::SEEN_BIT] = 1'b1;
    end
    if (wr_i && (addr_i == edge_timing_pkg::IRQ_MASK_OFS)) begin
      st_nxt.imask = wdata_i[edge_timing_pkg::IRQ_W-1:0];
    end
    if (rd_ist) begin
      st_nxt.ist = '0;
    end
    // a new event in the clearing read cycle still lands
    if (qual) begin
      st_nxt.ist[edge_timing_pkg::IRQ_EDGE] = 1'b1;
    end
    if (pol_edge && !pass) begin
      st_nxt.ist[edge_timing_pkg::IRQ_DROP] = 1'b1;
    end
    st_nxt.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        edge_timing_pkg::MEASURE_UNIT_CONTROL_OFS: st_nxt.rdata = st_r.ctrl;
        edge_timing_pkg::IRQ_STATUS_OFS:   st_nxt.rdata[1:0] = st_r.ist;
        edge_timing_pkg::IRQ_MASK_OFS:     st_nxt.rdata[1:0] = st_r.imask;
        edge_timing_pkg::UNIT_STATE_OFS:
          st_nxt.rdata[3:0] = {cur, st_r.prev, pass, running};
        default:                           st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r.ctrl  <= edge_timing_pkg::CTRL_RESET;
      st_r.ist   <= edge_timing_pkg::IRQ_RESET;
      st_r.imask <= edge_timing_pkg::IRQ_RESET;
      st_r.prev  <= 1'b0;
      st_r.evt   <= 1'b0;
      st_r.rdata <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rdata_o                = st_r.rdata;
  assign module_running_o       = running;
  assign delay_gen_o            = running & st_r.ctrl[edge_timing_pkg::DELAY_GEN_ENABLE_BIT];
  assign edge_b_event_o         = st_r.evt;
  // the sink never engages on its own, only from the control bit
  assign sample_cap_discharge_o = st_r.ctrl[edge_timing_pkg::DISCH_BIT];
  assign irq_o                  = |(st_r.ist & st_r.imask);

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  fall_edge_a: assert property (
    (pass && !pol && st_r.prev && !cur) |=> st_r.ctrl[25] && edge_b_event_o)
    else $error("falling edge not counted");

  rise_edge_a: assert property (
    (pass && pol && !st_r.prev && cur) |=> st_r.ctrl[25] && edge_b_event_o)
    else $error("rising edge not counted");

  wrong_edge_a: assert property (
    (!pol && !st_r.prev && cur) |=> !edge_b_event_o)
    else $error("rising edge counted under falling polarity");

  sel_comp_a: assert property (
    (sel == 4'he) |-> cur == edge_src_i.comparator_b_output)
    else $error("code e does not pick comparator b");

  sel_capture_a: assert property (
    (sel == 4'h9) |-> cur == edge_src_i.input_capture_one)
    else $error("code 9 does not pick capture one");

  sel_pin_a: assert property (
    (sel == 4'h8) |-> cur == edge_src_i.edge_pin_thirteen)
    else $error("code 8 does not pick pin thirteen");

  sel_timer_a: assert property (
    (sel == 4'h0) |-> cur == edge_src_i.first_timer)
    else $error("code 0 does not pick the timer");

  rsvd_zero_a: assert property (
    (rd_i && addr_i == 8'h00) |=> (rdata_o[17:16] == 2'h0) && !rdata_o[14])
    else $error("unimplemented control bits read nonzero");

  unit_off_a: assert property (
    !st_r.ctrl[15] |-> !module_running_o && !delay_gen_o)
    else $error("unit runs while switched off");

  idle_keep_a: assert property (
    (st_r.ctrl[15] && (!st_r.ctrl[13] || !idle_i)) |-> module_running_o)
    else $error("unit stopped without cause");

  delay_gen_enable_off_a: assert property (
    !st_r.ctrl[12] |-> !delay_gen_o)
    else $error("delay generation without enable");

  gate_block_a: assert property (
    (!st_r.ctrl[11] && !wr_ctrl) |=> !edge_b_event_o && $stable(st_r.ctrl[25]))
    else $error("edge passed while blocked");

  discharge_a: assert property (
    (wr_ctrl && !wdata_i[9]) |=> !sample_cap_discharge_o)
    else $error("sink engaged without control bit");

  keep_sel_a: assert property (
    !wr_ctrl |=> $stable(sel) && $stable(pol))
    else $error("source settings changed without a write");

  sel_cap4_a: assert property (
    (sel == 4'hf) |-> cur == edge_src_i.input_capture_four)
    else $error("code f does not pick capture four");

  sel_compa_a: assert property (
    (sel == 4'hd) |-> cur == edge_src_i.comparator_a_output)
    else $error("code d does not pick comparator a");

  sel_busclk_a: assert property (
    (sel == 4'hc) |-> cur == edge_src_i.peripheral_bus_clock)
    else $error("code c does not pick the bus clock");

  sel_cap3_a: assert property (
    (sel == 4'hb) |-> cur == edge_src_i.input_capture_three)
    else $error("code b does not pick capture three");

  sel_cap2_a: assert property (
    (sel == 4'ha) |-> cur == edge_src_i.input_capture_two)
    else $error("code a does not pick capture two");

  sel_pin12_a: assert property (
    (sel == 4'h7) |-> cur == edge_src_i.edge_pin_twelve)
    else $error("code 7 does not pick pin twelve");

  sel_pin11_a: assert property (
    (sel == 4'h6) |-> cur == edge_src_i.edge_pin_eleven)
    else $error("code 6 does not pick pin eleven");

  sel_pin10_a: assert property (
    (sel == 4'h5) |-> cur == edge_src_i.edge_pin_ten)
    else $error("code 5 does not pick pin ten");

  sel_pin9_a: assert property (
    (sel == 4'h4) |-> cur == edge_src_i.edge_pin_nine)
    else $error("code 4 does not pick pin nine");

  sel_pin1_a: assert property (
    (sel == 4'h3) |-> cur == edge_src_i.edge_pin_one)
    else $error("code 3 does not pick pin one");

  sel_pin2_a: assert property (
    (sel == 4'h2) |-> cur == edge_src_i.edge_pin_two)
    else $error("code 2 does not pick pin two");

  sel_compare_a: assert property (
    (sel == 4'h1) |-> cur == edge_src_i.output_compare_one)
    else $error("code 1 does not pick compare one");

  wrong_rise_a: assert property (
    (pol && st_r.prev && !cur) |=> !edge_b_event_o)
    else $error("falling edge counted under rising polarity");

  event_pulse_a: assert property (
    edge_b_event_o |=> !edge_b_event_o)
    else $error("edge event longer than one cycle");

  seen_hold_a: assert property (
    (st_r.ctrl[25] && !wr_ctrl) |=> st_r.ctrl[25])
    else $error("seen flag lost without a write");

  seen_write_a: assert property (
    (wr_ctrl && !qual) |=> st_r.ctrl[25] == $past(wdata_i[25]))
    else $error("seen flag write not taken");

  seen_wins_a: assert property (
    (wr_ctrl && qual) |=> st_r.ctrl[25])
    else $error("seen flag set lost to a write");

  ctrl_write_a: assert property (
    wr_ctrl |=> st_r.ctrl[24:0] == ($past(wdata_i[24:0]) & 25'h1fcbfff))
    else $error("control write stored wrong value");

  rsvd_store_a: assert property (
    (st_r.ctrl[17:16] == 2'h0) && !st_r.ctrl[14])
    else $error("unimplemented control bits hold ones");

  idle_stop_a: assert property (
    (st_r.ctrl[15] && st_r.ctrl[13] && idle_i) |-> !module_running_o)
    else $error("unit runs in idle with stop set");

  delay_gen_enable_on_a: assert property (
    (module_running_o && st_r.ctrl[12]) |-> delay_gen_o)
    else $error("delay generation missing while enabled");

  gate_pass_a: assert property (
    (module_running_o && st_r.ctrl[11] && pol_edge) |=> edge_b_event_o)
    else $error("passed edge not counted");

  off_drop_a: assert property (
    (pol_edge && !pass) |=> st_r.ist[1])
    else $error("blocked edge not flagged as dropped");

  off_quiet_a: assert property (
    !module_running_o |=> !edge_b_event_o)
    else $error("edge counted while unit stopped");

  discharge_on_a: assert property (
    (wr_ctrl && wdata_i[9]) |=> sample_cap_discharge_o)
    else $error("sink not engaged by control bit");

  irq_set_a: assert property (
    (qual && st_r.imask[0]) |=> irq_o)
    else $error("counted edge raised no interrupt");

  status_clear_a: assert property (
    (rd_ist && !qual && !(pol_edge && !pass)) |=> st_r.ist == 2'h0)
    else $error("status not cleared by read");

  rdata_idle_a: assert property (
    !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data stands without a read");

  rdata_ctrl_a: assert property (
    (rd_i && addr_i == 8'h00) |=> rdata_o == $past(st_r.ctrl))
    else $error("control read returned wrong value");

endmodule : edge_timing_unit_control

// *** sim/edge_src_model.sv ***
// model of the edge sources that sit around the timing unit
`timescale 1ns/1ps
module edge_src_model (
  input  wire logic                   ref_clk_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic                   level_i,
  output      edge_timing_pkg::edge_src_s src_o
);
  // unselected sources keep toggling, so a wrong source pick shows as a stray edge
  logic [15:0] noise_r = 16'h5a5a;
  always @(posedge ref_clk_i) begin
    noise_r <= ~noise_r;
  end
  assign src_o = (noise_r & ~(16'h0001 << sel_i)) | ({15'h0000, level_i} << sel_i);
endmodule : edge_src_model

// *** sim/edge_timing_unit_control_tb_top.sv ***
// self-checking bench of the edge timing control block
`timescale 1ns/1ps
module edge_timing_unit_control_tb_top;
  typedef struct packed {
    logic [31:0] ctrl;
    logic        idle;
    logic        lvl;
    logic        ev;
    logic        drop;
  } row_s;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0000_0000;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        idle_i    = 1'b0;
  logic [3:0]  sel_m     = 4'h0;
  logic        lvl_m     = 1'b0;
  logic [1:0]  mask_v    = 2'h3;
  logic [31:0] rdata_o;
  logic [31:0] d;
  logic        run_o, dgen_o, ev_o, disch_o, irq_o;
  edge_timing_pkg::edge_src_s src;
  row_s        rows [21];
  int          fails  = 0;
  int          checks = 0;

  edge_src_model srcm (.ref_clk_i(ref_clk_i), .sel_i(sel_m), .level_i(lvl_m), .src_o(src));
  edge_timing_unit_control dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .edge_src_i(src), .idle_i(idle_i), .module_running_o(run_o), .delay_gen_o(dgen_o),
    .edge_b_event_o(ev_o), .sample_cap_discharge_o(disch_o), .irq_o(irq_o));

  always #5 ref_clk_i = ~ref_clk_i;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // ************************************************************
  // one row: settle the source, clear flags, then make one edge
  // ************************************************************
  task automatic run_row(input row_s r);
    logic [31:0] c;
    logic [31:0] n;
    logic        run;
    c   = r.ctrl;
    run = c[15] & ~(c[13] & r.idle);
    @(posedge ref_clk_i);
    sel_m  <= c[21:18];
    lvl_m  <= ~r.lvl;
    idle_i <= r.idle;
    // the source switch itself can look like an edge, so write twice to clear it
    wr(8'h00, c | 32'h0003_4000);
    repeat (2) @(posedge ref_clk_i);
    wr(8'h00, c | 32'h0003_4000);
    rd(8'h04);
    @(posedge ref_clk_i);
    lvl_m <= r.lvl;
    n = 32'h0000_0000;
    repeat (4) begin
      @(posedge ref_clk_i);
      #1 n = n + {31'h0, ev_o};
    end
    chk("event", {31'h0, r.ev}, n);
    chk("irq", {31'h0, |({r.drop, r.ev} & mask_v)}, {31'h0, irq_o});
    chk("running", {31'h0, run}, {31'h0, run_o});
    chk("delay_gen", {31'h0, run & c[12]}, {31'h0, dgen_o});
    // the converter is taken as sampling for the whole row, so the sink may stay on
    chk("discharge", {31'h0, c[9]}, {31'h0, disch_o});
    rd(8'h00);
    chk("control", c | {6'h00, r.ev, 25'h0}, d);
    rd(8'h04);
    chk("status", {30'h0, r.drop, r.ev}, d);
  endtask : run_row

  initial begin
    #100us;
    fails++;
    wrap_up();
  end

  initial begin
    for (int i = 0; i < 16; i++) begin
      rows[i] = '{32'h0000_8800 | {9'h000, i[0], i[3:0], 18'h00000}, 1'b0, i[0], 1'b1, 1'b0};
    end
    rows[14].ctrl = rows[14].ctrl | 32'h0000_1000;
    rows[5].ctrl  = rows[5].ctrl | 32'h0000_0200;
    rows[16] = '{32'h0000_8000, 1'b0, 1'b0, 1'b0, 1'b1};
    rows[17] = '{32'h0040_1a00, 1'b0, 1'b1, 1'b0, 1'b1};
    rows[18] = '{32'h0040_8800, 1'b0, 1'b0, 1'b0, 1'b0};
    rows[19] = '{32'h0000_a800, 1'b1, 1'b0, 1'b0, 1'b1};
    rows[20] = '{32'h0004_8800, 1'b1, 1'b0, 1'b1, 1'b0};
    // a falling reset edge is needed, an initialised low level would not trigger it
    reset_n_i <= 1'b0;
    #1;
    chk("reset rdata", 32'h0, rdata_o);
    chk("reset irq", 32'h0, {31'h0, irq_o});
    chk("reset running", 32'h0, {31'h0, run_o});
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd(8'h00);
    chk("control reset", 32'h0, d);
    rd(8'h08);
    chk("mask reset", 32'h0, d);
    wr(8'h08, 32'h0000_0003);
    for (int i = 0; i < 21; i++) begin
      run_row(rows[i]);
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10);
    chk("unmapped", 32'h0, d);
    rd(8'h00);
    chk("control kept", rows[20].ctrl | 32'h0200_0000, d);
    mask_v = 2'h2;
    wr(8'h08, 32'h0000_0002);
    rd(8'h08);
    chk("mask", 32'h0000_0002, d);
    run_row(rows[0]);
    wrap_up();
  end
endmodule : edge_timing_unit_control_tb_top
